// file: core/cso_lock_class.sv
`timescale 1ns/1ps
`default_nettype none
module cso_lock_class (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Receiver pins
  input wire logic lock_pin,
  input wire logic sync_pin,
  // Class
  output cso_pkg::cso_class_t cls
);
  import cso_pkg::*;

  cso_lc_state_t s;
  cso_lc_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.s1_lock = lock_pin;
    next_s.s2_lock = s.s1_lock;
    next_s.s1_sync = sync_pin;
    next_s.s2_sync = s.s1_sync;
    // Sync only counts on top of a lock
    if (!s.s2_lock) begin
      next_s.cls = CSO_NO_SIG;
    end else if (s.s2_sync) begin
      next_s.cls = CSO_SYNC;
    end else begin
      next_s.cls = CSO_LOCK;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cls = s.cls;
endmodule
`default_nettype wire

// file: core/cso_map.svh
// Overview of operation
// - Reference is internal master, word, MADI or AES
// - Unlocked reference falls over to next locked input
// - No usable input means internal master clock
// - Report used reference apart from requested one
// - Classify each input: none, lock or sync
// - AES channel status consumer or professional
// - Each MADI output carries 56 or 64 channels
// - Word clock output follows current sample rate
// - Base-rate option keeps word clock at 32-48k
// - MADI above 48k: legacy or native double frame
// - Record processing from inputs, or outputs on loopback
// - Pass channel status and track markers through
// - Redundancy limits recorded inputs to 66 channels
// - Redundancy fails over to a backup MADI input
// - Mirror first MADI output, outputs become 70
// - Failed update boots secondary image next cold start
`ifndef CSO_MAP_SVH
`define CSO_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CSO_OFF_CTRL 12'h000
`define CSO_OFF_MADI 12'h004
`define CSO_OFF_RATE 12'h008
`define CSO_OFF_STAT 12'h00C
`define CSO_OFF_BOOT 12'h010

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSO_CTRL_REQ 0
`define CSO_CTRL_AESPRO 2
`define CSO_CTRL_WCBASE 3
`define CSO_CTRL_PROC 4
`define CSO_CTRL_LOOP 5
`define CSO_CTRL_CSPASS 6
`define CSO_CTRL_REDUND 7
`define CSO_CTRL_MIRROR 8
`define CSO_CTRL_MSEL 9
`define CSO_MADI_CH56 0
`define CSO_MADI_N96 4
`define CSO_STAT_CUR 0
`define CSO_STAT_MCUR 2
`define CSO_STAT_CLS 4
`define CSO_BOOT_FAIL 0
`define CSO_BOOT_CLR 1

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CSO_RST_REQ 2'h0
`define CSO_RST_MSEL 2'h0
`define CSO_RST_SPEED 2'h0
`define CSO_RED_REC_CH 8'h42
`define CSO_MIR_OUT_CH 8'h46

`endif

// file: core/cso_pkg.sv
package cso_pkg;

  typedef enum logic [1:0] {
    CSO_SRC_INT = 2'b00,
    CSO_SRC_WORD = 2'b01,
    CSO_SRC_MADI = 2'b10,
    CSO_SRC_AES = 2'b11
  } cso_src_t;

  typedef enum logic [1:0] {
    CSO_NO_SIG = 2'b00,
    CSO_LOCK = 2'b01,
    CSO_SYNC = 2'b10
  } cso_class_t;

  typedef enum logic [1:0] {
    CSO_SPD_SINGLE = 2'b00,
    CSO_SPD_DOUBLE = 2'b01,
    CSO_SPD_QUAD = 2'b10
  } cso_speed_t;

  typedef struct packed {
    logic s1_lock;
    logic s2_lock;
    logic s1_sync;
    logic s2_sync;
    cso_class_t cls;
  } cso_lc_state_t;

  typedef struct packed {
    cso_src_t clk_req;
    logic aes_pro;
    logic wc_base;
    logic proc_rec;
    logic loopback;
    logic cs_pass;
    logic redund;
    logic mirror;
    logic [1:0] madi_sel;
    logic [2:0] ch56;
    logic [2:0] n96;
    cso_speed_t speed;
    cso_src_t clk_cur;
    logic [1:0] madi_cur;
    logic proc_in;
    logic proc_out;
    cso_speed_t wc_speed;
    logic [7:0] rec_lim;
    logic [7:0] out_cnt;
    logic [1:0] tx_src2;
    logic [1:0] tx_src3;
    logic boot_bak;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cso_state_t;

endpackage

// file: core/cso_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cso_map.svh"
module cso_top #(
  parameter logic [7:0] REC_CH_FULL = 8'hFF,
  parameter logic [7:0] OUT_CH_FULL = 8'hFF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver status pins: 0 word, 1 AES, 2..4 MADI 1..3
  input wire logic [4:0] rx_lock,
  input wire logic [4:0] rx_sync,
  // Update engine
  input wire logic prog_fail,
  // Clock selection
  output cso_pkg::cso_src_t clk_cur_src,
  output logic [1:0] madi_in_cur,
  // Output formats
  output logic aes_cs_pro,
  output logic [2:0] madi_ch56,
  output logic [2:0] madi_native96,
  output cso_pkg::cso_speed_t wc_out_speed,
  // Routing and options
  output logic proc_in_rec,
  output logic proc_out_rec,
  output logic cs_pass_en,
  output logic [7:0] rec_ch_limit,
  output logic [7:0] out_ch_count,
  output logic [1:0] madi2_tx_src,
  output logic [1:0] madi3_tx_src,
  // Boot image
  output logic boot_backup
);
  import cso_pkg::*;

  // ----------------------------------------
  // Input classification
  // ----------------------------------------
  cso_class_t cls [5];
  logic [4:0] usable;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_rx
      cso_lock_class u_cls (
        .mclk(mclk),
        .rst(rst),
        .lock_pin(rx_lock[gi]),
        .sync_pin(rx_sync[gi]),
        .cls(cls[gi])
      );
      assign usable[gi] = (cls[gi] != CSO_NO_SIG);
    end
  endgenerate

  cso_state_t s;
  cso_state_t next_s;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [2:0] madi_ok;
    logic [3:0] src_ok;
    logic [1:0] nm;
    logic [1:0] cand;
    logic found;
    logic access;
    logic [31:0] rd;
    logic hit;
    logic fail_set;
    logic fail_clr;
    madi_ok = usable[4:2];
    src_ok = 4'h0;
    nm = s.madi_cur;
    cand = 2'h0;
    found = 1'b0;
    access = 1'b0;
    rd = 32'h0;
    hit = 1'b0;
    fail_set = 1'b0;
    fail_clr = 1'b0;
    next_s = s;

    // Register write at the completing edge only
    access = psel && penable && s.pready;
    if (access && pwrite) begin
      unique case (paddr)
        `CSO_OFF_CTRL: begin
          next_s.clk_req = cso_src_t'(pwdata[`CSO_CTRL_REQ +: 2]);
          next_s.aes_pro = pwdata[`CSO_CTRL_AESPRO];
          next_s.wc_base = pwdata[`CSO_CTRL_WCBASE];
          next_s.proc_rec = pwdata[`CSO_CTRL_PROC];
          next_s.loopback = pwdata[`CSO_CTRL_LOOP];
          next_s.cs_pass = pwdata[`CSO_CTRL_CSPASS];
          next_s.redund = pwdata[`CSO_CTRL_REDUND];
          next_s.mirror = pwdata[`CSO_CTRL_MIRROR];
          next_s.madi_sel = pwdata[`CSO_CTRL_MSEL +: 2];
        end
        `CSO_OFF_MADI: begin
          next_s.ch56 = pwdata[`CSO_MADI_CH56 +: 3];
          next_s.n96 = pwdata[`CSO_MADI_N96 +: 3];
        end
        `CSO_OFF_RATE: begin
          next_s.speed = cso_speed_t'(pwdata[1:0]);
        end
        `CSO_OFF_BOOT: begin
          fail_set = pwdata[`CSO_BOOT_FAIL];
          fail_clr = pwdata[`CSO_BOOT_CLR];
        end
        default: begin
        end
      endcase
    end

    // Failure report wins over a clear in the same cycle
    if (prog_fail || fail_set) begin
      next_s.boot_bak = 1'b1;
    end else if (fail_clr) begin
      next_s.boot_bak = 1'b0;
    end

    // MADI input in use
    if (!s.redund) begin
      nm = (s.madi_sel == 2'h3) ? 2'h0 : s.madi_sel;
    end else if (!madi_ok[s.madi_cur]) begin
      // Backups are tried in port order after the failed one
      for (int k = 1; k < 3; k++) begin
        cand = 2'((int'(s.madi_cur) + k) % 3);
        if (!found && madi_ok[cand]) begin
          nm = cand;
          found = 1'b1;
        end
      end
    end
    next_s.madi_cur = nm;

    // Reference in use
    src_ok[CSO_SRC_INT] = 1'b1;
    src_ok[CSO_SRC_WORD] = usable[0];
    src_ok[CSO_SRC_MADI] = madi_ok[nm];
    src_ok[CSO_SRC_AES] = usable[1];
    found = 1'b0;
    if (s.clk_req == CSO_SRC_INT) begin
      next_s.clk_cur = CSO_SRC_INT;
    end else if (src_ok[s.clk_req]) begin
      // Requested input is watched all the time
      next_s.clk_cur = s.clk_req;
    end else begin
      next_s.clk_cur = CSO_SRC_INT;
      for (int k = 1; k < 3; k++) begin
        cand = 2'(((int'(s.clk_req) - 1 + k) % 3) + 1);
        if (!found && src_ok[cand]) begin
          next_s.clk_cur = cso_src_t'(cand);
          found = 1'b1;
        end
      end
    end

    // Word clock rate
    if (s.wc_base) begin
      next_s.wc_speed = CSO_SPD_SINGLE;
    end else begin
      next_s.wc_speed = s.speed;
    end

    // Processing placement
    next_s.proc_in = s.proc_rec && !s.loopback;
    next_s.proc_out = s.proc_rec && s.loopback;

    // Channel counts
    next_s.rec_lim = s.redund ? `CSO_RED_REC_CH : REC_CH_FULL;
    next_s.out_cnt = s.mirror ? `CSO_MIR_OUT_CH : OUT_CH_FULL;
    next_s.tx_src2 = s.mirror ? 2'h0 : 2'h1;
    next_s.tx_src3 = s.mirror ? 2'h0 : 2'h2;

    // Read mux
    hit = 1'b1;
    unique case (paddr)
      `CSO_OFF_CTRL: begin
        rd[`CSO_CTRL_REQ +: 2] = s.clk_req;
        rd[`CSO_CTRL_AESPRO] = s.aes_pro;
        rd[`CSO_CTRL_WCBASE] = s.wc_base;
        rd[`CSO_CTRL_PROC] = s.proc_rec;
        rd[`CSO_CTRL_LOOP] = s.loopback;
        rd[`CSO_CTRL_CSPASS] = s.cs_pass;
        rd[`CSO_CTRL_REDUND] = s.redund;
        rd[`CSO_CTRL_MIRROR] = s.mirror;
        rd[`CSO_CTRL_MSEL +: 2] = s.madi_sel;
      end
      `CSO_OFF_MADI: begin
        rd[`CSO_MADI_CH56 +: 3] = s.ch56;
        rd[`CSO_MADI_N96 +: 3] = s.n96;
      end
      `CSO_OFF_RATE: begin
        rd[1:0] = s.speed;
      end
      `CSO_OFF_STAT: begin
        rd[`CSO_STAT_CUR +: 2] = s.clk_cur;
        rd[`CSO_STAT_MCUR +: 2] = s.madi_cur;
        for (int i = 0; i < 5; i++) begin
          rd[`CSO_STAT_CLS + 2 * i +: 2] = cls[i];
        end
      end
      `CSO_OFF_BOOT: begin
        rd[`CSO_BOOT_FAIL] = s.boot_bak;
      end
      default: begin
        hit = 1'b0;
      end
    endcase

    // One wait state, then a single ready cycle
    next_s.pready = psel && penable && !s.pready;
    if (psel && penable && !s.pready) begin
      next_s.prdata = pwrite ? 32'h0 : rd;
      next_s.pslverr = !hit;
    end else begin
      next_s.prdata = 32'h0;
      next_s.pslverr = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.clk_req <= cso_src_t'(`CSO_RST_REQ);
      s.madi_sel <= `CSO_RST_MSEL;
      s.speed <= cso_speed_t'(`CSO_RST_SPEED);
      s.rec_lim <= REC_CH_FULL;
      s.out_cnt <= OUT_CH_FULL;
      s.tx_src2 <= 2'h1;
      s.tx_src3 <= 2'h2;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign clk_cur_src = s.clk_cur;
  assign madi_in_cur = s.madi_cur;
  assign aes_cs_pro = s.aes_pro;
  assign madi_ch56 = s.ch56;
  assign madi_native96 = s.n96;
  assign wc_out_speed = s.wc_speed;
  assign proc_in_rec = s.proc_in;
  assign proc_out_rec = s.proc_out;
  assign cs_pass_en = s.cs_pass;
  assign rec_ch_limit = s.rec_lim;
  assign out_ch_count = s.out_cnt;
  assign madi2_tx_src = s.tx_src2;
  assign madi3_tx_src = s.tx_src3;
  assign boot_backup = s.boot_bak;
endmodule
`default_nettype wire

// file: tb/cso_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module cso_far_end (
  // Clock
  input wire logic mclk,
  // Wanted line state
  input wire logic [4:0] want_lock,
  input wire logic [4:0] want_sync,
  // Receiver status
  output var logic [4:0] rx_lock = 5'h00,
  output var logic [4:0] rx_sync = 5'h00
);
  // No sync on a line that carries no signal
  always @(posedge mclk) begin
    rx_lock <= want_lock;
    rx_sync <= want_sync & want_lock;
  end
endmodule
`default_nettype wire

// file: tb/cso_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cso_top_properties #(
  parameter logic [7:0] REC_CH_FULL = 8'hFF,
  parameter logic [7:0] OUT_CH_FULL = 8'hFF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and outputs
  input wire logic [4:0] rx_lock,
  input wire logic prog_fail,
  input wire cso_pkg::cso_src_t clk_cur_src,
  input wire logic aes_cs_pro,
  input wire logic [2:0] madi_ch56,
  input wire logic proc_in_rec,
  input wire logic [7:0] rec_ch_limit,
  input wire logic [7:0] out_ch_count,
  input wire logic [1:0] madi2_tx_src,
  input wire logic [1:0] madi3_tx_src,
  input wire logic boot_backup
);
  import cso_pkg::*;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);
  wire acc = psel & penable;
  wire wr_ctrl = acc & pready & pwrite & (paddr == 12'h000);
  wire wr_madi = acc & pready & pwrite & (paddr == 12'h004);
  AST_ACK_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ACK_WAIT: assert property (acc && !pready |=> pready)
    else $error("no answer in second access cycle");
  AST_UNMAPPED: assert property (pready && paddr >= 12'h014 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_AES: assert property (wr_ctrl |=> aes_cs_pro == $past(pwdata[2]))
    else $error("channel status format wrong");
  AST_CH56: assert property (wr_madi |=> madi_ch56 == $past(pwdata[2:0]))
    else $error("channel count wrong");
  AST_PROC: assert property (wr_ctrl |-> ##2 proc_in_rec ==
    ($past(pwdata[4], 2) && !$past(pwdata[5], 2))) else $error("record path wrong");
  AST_INT: assert property ((rx_lock == 5'h00)[*6] |-> clk_cur_src == CSO_SRC_INT)
    else $error("not internal without lock");
  AST_MIRROR: assert property (madi2_tx_src == 2'h0 ?
    (madi3_tx_src == 2'h0 && out_ch_count == 8'h46) : out_ch_count == OUT_CH_FULL)
    else $error("mirror outputs disagree");
  AST_BOOT_SET: assert property (prog_fail |=> boot_backup)
    else $error("failed update not kept");
  AST_REC: assert property (rec_ch_limit == 8'h42 || rec_ch_limit == REC_CH_FULL)
    else $error("record limit out of range");
endmodule
bind cso_top cso_top_properties #(.REC_CH_FULL(REC_CH_FULL), .OUT_CH_FULL(OUT_CH_FULL))
  cso_top_properties_inst (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .rx_lock, .prog_fail, .clk_cur_src, .aes_cs_pro,
  .madi_ch56, .proc_in_rec, .rec_ch_limit, .out_ch_count, .madi2_tx_src,
  .madi3_tx_src, .boot_backup);
`default_nettype wire

// file: tb/tb_clock_source_and_output_format.sv
`timescale 1ns/1ps
`default_nettype none
module tb_clock_source_and_output_format;
  import cso_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, prog_fail = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, boot_backup, aes_cs_pro, proc_in_rec, proc_out_rec, cs_pass_en;
  logic [4:0] lk = 5'h00, sy = 5'h00, rx_lock, rx_sync;
  logic [1:0] madi_in_cur, madi2_tx_src, madi3_tx_src;
  logic [2:0] madi_ch56, madi_native96;
  logic [7:0] rec_ch_limit, out_ch_count;
  cso_src_t clk_cur_src;
  cso_speed_t wc_out_speed;
  int miscompares = 0, checks = 0, cycles = 0;
  initial forever #25 mclk = ~mclk;
  cso_top #(.REC_CH_FULL(8'hC0), .OUT_CH_FULL(8'hC4)) cso_top_inst (.mclk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_lock, .rx_sync,
    .prog_fail, .clk_cur_src, .madi_in_cur, .aes_cs_pro, .madi_ch56, .madi_native96,
    .wc_out_speed, .proc_in_rec, .proc_out_rec, .cs_pass_en, .rec_ch_limit,
    .out_ch_count, .madi2_tx_src, .madi3_tx_src, .boot_backup);
  cso_far_end cso_far_end_inst (.mclk, .want_lock(lk), .want_sync(sy), .rx_lock, .rx_sync);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop;
    end
  end
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // Hold the request until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) miscompares++;
  endtask
  // Derived outputs settle two edges after the write
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    cyc(3);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task pin(input logic [4:0] l, input logic [4:0] s);
    lk <= l;
    sy <= s;
    cyc(8);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    chk(clk_cur_src, CSO_SRC_INT);
    chk({boot_backup, rec_ch_limit, out_ch_count, madi2_tx_src, madi3_tx_src},
      {1'b0, 8'hC0, 8'hC4, 2'h1, 2'h2});
    apb(1'b0, 12'h014, 32'h0);
    // Refusal flag and data compared apart, the word is only 32 bits
    chk(e, 32'h1);
    chk(q, 32'h0);
    rd(12'h000, 32'h0);
    $display("test reset done");
  endtask
  task t_clock;
    wr(12'h000, 32'h1);
    chk(clk_cur_src, CSO_SRC_INT);
    pin(5'h01, 5'h00);
    chk(clk_cur_src, CSO_SRC_WORD);
    rd(12'h00C, 32'h11);
    pin(5'h01, 5'h01);
    rd(12'h00C, 32'h21);
    pin(5'h06, 5'h00);
    chk(clk_cur_src, CSO_SRC_MADI);
    pin(5'h02, 5'h00);
    chk(clk_cur_src, CSO_SRC_AES);
    pin(5'h03, 5'h00);
    chk(clk_cur_src, CSO_SRC_WORD);
    pin(5'h00, 5'h00);
    chk(clk_cur_src, CSO_SRC_INT);
    wr(12'h000, 32'h3);
    pin(5'h1F, 5'h00);
    chk(clk_cur_src, CSO_SRC_AES);
    wr(12'h000, 32'h0);
    chk(clk_cur_src, CSO_SRC_INT);
    $display("test clock done");
  endtask
  task t_format;
    wr(12'h000, 32'h4);
    chk(aes_cs_pro, 1'b1);
    wr(12'h000, 32'h0);
    chk(aes_cs_pro, 1'b0);
    wr(12'h004, 32'hFFFF_FF35);
    chk({madi_native96, madi_ch56}, 6'h1D);
    rd(12'h004, 32'h35);
    wr(12'h008, 32'h2);
    chk(wc_out_speed, CSO_SPD_QUAD);
    wr(12'h000, 32'h8);
    chk(wc_out_speed, CSO_SPD_SINGLE);
    wr(12'h008, 32'h1);
    chk(wc_out_speed, CSO_SPD_SINGLE);
    wr(12'h000, 32'h0);
    chk(wc_out_speed, CSO_SPD_DOUBLE);
    $display("test format done");
  endtask
  task t_opts;
    wr(12'h000, 32'h10);
    chk({proc_in_rec, proc_out_rec}, 2'h2);
    wr(12'h000, 32'h30);
    chk({proc_in_rec, proc_out_rec}, 2'h1);
    wr(12'h000, 32'h40);
    chk({cs_pass_en, proc_in_rec}, 2'h2);
    wr(12'h000, 32'h100);
    chk({madi2_tx_src, madi3_tx_src, out_ch_count}, 12'h046);
    wr(12'h000, 32'h80);
    chk({rec_ch_limit, out_ch_count}, 16'h42C4);
    pin(5'h14, 5'h00);
    chk(madi_in_cur, 2'h0);
    pin(5'h10, 5'h00);
    chk(madi_in_cur, 2'h2);
    pin(5'h18, 5'h00);
    chk(madi_in_cur, 2'h2);
    pin(5'h08, 5'h00);
    chk(madi_in_cur, 2'h1);
    wr(12'h000, 32'h400);
    chk(madi_in_cur, 2'h2);
    $display("test options done");
  endtask
  task t_boot;
    prog_fail <= 1'b1;
    cyc(1);
    prog_fail <= 1'b0;
    cyc(2);
    chk(boot_backup, 1'b1);
    rd(12'h010, 32'h1);
    wr(12'h010, 32'h2);
    chk(boot_backup, 1'b0);
    wr(12'h010, 32'h3);
    chk(boot_backup, 1'b1);
    $display("test boot done");
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_clock;
    t_format;
    t_opts;
    t_boot;
    report_and_stop;
  end
endmodule
`default_nettype wire
